// File: design/sfpi_addr_map.v
// Purpose: address split and erase span for the flash array
// Assumes: sector 64 KB, page 256 bytes, subsector size a parameter
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "sfpi_map.vh"

module sfpi_addr_map
#(
   parameter SUB_LSB = `SFPI_SUB_LSB_DEF
)
(
   // request
   input  wire [`SFPI_ADDR_W-1:0]   addr_i,
   input  wire [1:0]                erase_kind_i,
   // decoded address
   output wire [`SFPI_SECTOR_W-1:0] sector_o,
   output wire [`SFPI_PAGE_W-1:0]   page_o,
   // erase span, inclusive
   output reg  [`SFPI_ARRAY_W-1:0]  erase_first_o,
   output reg  [`SFPI_ARRAY_W-1:0]  erase_last_o
);

   wire [`SFPI_ARRAY_W-1:0] arr = addr_i[`SFPI_ARRAY_W-1:0];

   assign sector_o = arr[`SFPI_ARRAY_W-1:`SFPI_SECTOR_LSB];
   assign page_o   = arr[`SFPI_ARRAY_W-1:`SFPI_PAGE_LSB];

   // span covering a block of 2**lsb bytes
   function [2*`SFPI_ARRAY_W-1:0] span;
      input [`SFPI_ARRAY_W-1:0] a;
      input integer             lsb;
      reg   [`SFPI_ARRAY_W-1:0] m;
      begin
         m    = ({`SFPI_ARRAY_W{1'b1}} >> (`SFPI_ARRAY_W - lsb));
         span = {a & ~m, a | m};
      end
   endfunction

   always @*
   begin
      case (erase_kind_i)
         `SFPI_ERASE_PAGE:
            {erase_first_o, erase_last_o} = span(arr, `SFPI_PAGE_LSB);
         `SFPI_ERASE_SUB:
            {erase_first_o, erase_last_o} = span(arr, SUB_LSB);
         `SFPI_ERASE_SECTOR:
            {erase_first_o, erase_last_o} = span(arr, `SFPI_SECTOR_LSB);
         default:
            {erase_first_o, erase_last_o} = span(arr, `SFPI_ARRAY_W);
      endcase
   end

endmodule // sfpi_addr_map

`default_nettype wire

// File: design/sfpi_pin_if.v
// Purpose: pin layer of a 16 Mbit serial flash, single/dual/quad read
// Assumes: serial clock far slower than ref_clk_i; reset stands for power-up
// Notes:   instruction decode lives above this block

`timescale 1ns/10ps
`default_nettype none
`include "sfpi_map.vh"

// Contract
// - read data bits leave on the serial output after clock falling edges
// - instruction, address and program bits sampled on clock rising edges
// - dual read drives lanes 0 and 1, input pin becomes output
// - quad read drives lanes 0 to 3 on the four data pins
// - select high deselects and floats the serial output
// - deselected device goes standby only after internal cycles end
// - select low enables and makes the device active
// - no decoding before a select falling edge after power-up
// - pause input suspends transfer without deselecting
// - while paused output floats, input and clock ignored
// - pause only honoured while selected
// - quad enable disables pause, pin becomes lane 3
// - quad enable disables write protect, pin becomes lane 2
// - write protect freezes the block protect bits
// - page program accepts one to 256 data bytes
// - page, subsector, sector and whole-array erase granularities
// - array decodes as thirty-two sectors of 512 Kb
module sfpi_pin_if
#(
   parameter SUB_LSB = `SFPI_SUB_LSB_DEF
)
(
   // clock and reset
   input  wire                      ref_clk_i,
   input  wire                      rst_n_i,
   // serial pins
   input  wire                      cs_n_i,
   input  wire                      sck_i,
   input  wire                      data_lane_0_i,
   output wire                      data_lane_0_o,
   output wire                      data_lane_0_oe_o,
   output wire                      data_lane_1_o,
   output wire                      data_lane_1_oe_o,
   input  wire                      wp_n_i,
   output wire                      data_lane_2_o,
   output wire                      data_lane_2_oe_o,
   input  wire                      hold_n_i,
   output wire                      data_lane_3_o,
   output wire                      data_lane_3_oe_o,
   // status from the core
   input  wire                      quad_enable_bit_i,
   input  wire [3:0]                block_protect_bits_i,
   input  wire                      busy_i,
   // receive side
   output reg  [7:0]                rx_byte_o,
   output reg                       rx_valid_o,
   output reg                       rx_first_o,
   // transmit side
   input  wire                      tx_en_i,
   input  wire [1:0]                tx_mode_i,
   input  wire [7:0]                tx_byte_i,
   output reg                       tx_take_o,
   // program byte count
   input  wire                      prog_phase_i,
   output reg  [`SFPI_CNT_W-1:0]    prog_count_o,
   output wire                      prog_len_ok_o,
   output reg                       prog_over_o,
   // address decode
   input  wire [`SFPI_ADDR_W-1:0]   addr_i,
   input  wire [1:0]                erase_kind_i,
   output wire [`SFPI_SECTOR_W-1:0] sector_o,
   output wire [`SFPI_PAGE_W-1:0]   page_o,
   output wire [`SFPI_ARRAY_W-1:0]  erase_first_o,
   output wire [`SFPI_ARRAY_W-1:0]  erase_last_o,
   // power and protection state
   output reg                       selected_o,
   output reg                       active_o,
   output reg                       standby_o,
   output reg                       armed_o,
   output reg                       paused_o,
   output reg                       bp_frozen_o,
   output reg  [3:0]                bp_held_o,
   output reg                       frame_end_o
);

   // synchronised pins: cs, sck, si, wp, hold
   wire [4:0] pin_s;
   wire       cs_n_s   = pin_s[4];
   wire       sck_s    = pin_s[3];
   wire       si_s     = pin_s[2];
   wire       wp_n_s   = pin_s[1];
   wire       hold_n_s = pin_s[0];

   sfpi_sync
   #(
      .WIDTH (5),
      .INIT  (5'h1F)
   )
   u_sync
   (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .async_i   ({cs_n_i, sck_i, data_lane_0_i, wp_n_i, hold_n_i}),
      .sync_o    (pin_s)
   );

   sfpi_addr_map
   #(
      .SUB_LSB (SUB_LSB)
   )
   u_map
   (
      .addr_i        (addr_i),
      .erase_kind_i  (erase_kind_i),
      .sector_o      (sector_o),
      .page_o        (page_o),
      .erase_first_o (erase_first_o),
      .erase_last_o  (erase_last_o)
   );

   // edge history
   reg cs_n_q;
   reg sck_q;
   reg hold_n_q;

   // edges found the same way for either idle level
   wire sck_rise  = sck_s & ~sck_q;
   wire sck_fall  = ~sck_s & sck_q;
   wire cs_fall   = ~cs_n_s & cs_n_q;
   wire cs_rise   = cs_n_s & ~cs_n_q;
   wire hold_fall = ~hold_n_s & hold_n_q;
   wire hold_rise = hold_n_s & ~hold_n_q;

   // shift state
   reg [7:0] rx_sh_q;
   reg [3:0] rx_cnt_q;
   reg       rx_first_q;
   reg [7:0] tx_sh_q;
   reg [3:0] tx_left_q;
   reg [1:0] tx_mode_q;
   reg       tx_live_q;
   reg [3:0] lane_q;
   reg       quad_ok;

   // live bit path: selected, armed and not paused
   wire live = selected_o & armed_o & ~paused_o;

   // requested mode, quad only when lanes 2 and 3 are free
   reg [1:0] mode_d;
   reg [3:0] step_d;
   always @*
   begin
      quad_ok = quad_enable_bit_i;
      mode_d  = tx_mode_i;
      if (tx_mode_i == `SFPI_MODE_QUAD && !quad_ok)
         mode_d = `SFPI_MODE_SINGLE;
      case (mode_d)
         `SFPI_MODE_DUAL: step_d = `SFPI_STEP_DUAL;
         `SFPI_MODE_QUAD: step_d = `SFPI_STEP_QUAD;
         default:         step_d = `SFPI_STEP_SINGLE;
      endcase
   end

   // next transmit byte: fresh load when the previous one is spent
   wire [7:0] tx_cur  = (tx_left_q == 4'h0) ? tx_byte_i : tx_sh_q;
   wire [3:0] tx_base = (tx_left_q == 4'h0) ? `SFPI_BYTE_BITS : tx_left_q;

   // select, power and power-up arming
   always @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         cs_n_q      <= 1'b1;
         sck_q       <= 1'b1;
         hold_n_q    <= 1'b1;
         selected_o  <= 1'b0;
         active_o    <= 1'b0;
         standby_o   <= 1'b1;
         armed_o     <= 1'b0;
         frame_end_o <= 1'b0;
      end
      else
      begin
         cs_n_q      <= cs_n_s;
         sck_q       <= sck_s;
         hold_n_q    <= hold_n_s;
         selected_o  <= ~cs_n_s;
         active_o    <= ~cs_n_s | busy_i;
         standby_o   <= cs_n_s & ~busy_i;
         // first select falling edge arms decoding
         if (cs_fall)
            armed_o <= 1'b1;
         frame_end_o <= cs_rise & armed_o;
      end
   end

   // pause handling
   always @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         paused_o <= 1'b0;
      else if (quad_enable_bit_i)
         paused_o <= 1'b0;
      else if (cs_n_s)
         paused_o <= 1'b0;
      // enter on falling, leave on rising edge
      else if (hold_fall)
         paused_o <= 1'b1;
      else if (hold_rise)
         paused_o <= 1'b0;
   end

   // receive shifter
   always @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         rx_sh_q    <= 8'h00;
         rx_cnt_q   <= 4'h0;
         rx_first_q <= 1'b1;
         rx_byte_o  <= 8'h00;
         rx_valid_o <= 1'b0;
         rx_first_o <= 1'b0;
      end
      else
      begin
         rx_valid_o <= 1'b0;
         if (!selected_o)
         begin
            rx_cnt_q   <= 4'h0;
            rx_first_q <= 1'b1;
         end
         // sample on rising edge; ignored while paused
         else if (live && sck_rise && !tx_live_q)
         begin
            rx_sh_q <= {rx_sh_q[6:0], si_s};
            if (rx_cnt_q == `SFPI_BYTE_BITS - 4'h1)
            begin
               rx_cnt_q   <= 4'h0;
               rx_byte_o  <= {rx_sh_q[6:0], si_s};
               rx_valid_o <= 1'b1;
               rx_first_o <= rx_first_q;
               rx_first_q <= 1'b0;
            end
            else
               rx_cnt_q <= rx_cnt_q + 4'h1;
         end
      end
   end

   // transmit shifter
   always @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         tx_sh_q   <= 8'h00;
         tx_left_q <= 4'h0;
         tx_mode_q <= `SFPI_MODE_SINGLE;
         tx_live_q <= 1'b0;
         lane_q    <= 4'h0;
         tx_take_o <= 1'b0;
      end
      else
      begin
         tx_take_o <= 1'b0;
         if (!selected_o || !tx_en_i)
         begin
            tx_left_q <= 4'h0;
            tx_live_q <= 1'b0;
         end
         // launch after falling edge; resume where stopped
         else if (live && sck_fall)
         begin
            tx_live_q <= 1'b1;
            tx_mode_q <= mode_d;
            tx_take_o <= (tx_left_q == 4'h0);
            tx_sh_q   <= tx_cur << step_d;
            tx_left_q <= tx_base - step_d;
            case (mode_d)
               // dual pairs bits on lanes 1 and 0
               `SFPI_MODE_DUAL: lane_q <= {2'h0, tx_cur[7], tx_cur[6]};
               // quad nibble over lanes 3 to 0
               `SFPI_MODE_QUAD: lane_q <= tx_cur[7:4];
               default:         lane_q <= {2'h0, tx_cur[7], 1'b0};
            endcase
         end
      end
   end

   // lane drivers
   // lanes float unless driving read data
   wire drive   = selected_o & ~paused_o & tx_live_q;
   wire multi   = (tx_mode_q == `SFPI_MODE_DUAL) || (tx_mode_q == `SFPI_MODE_QUAD);
   // upper lanes only under quad enable
   wire quad_on = (tx_mode_q == `SFPI_MODE_QUAD) & quad_ok;

   assign data_lane_0_o    = lane_q[0];
   assign data_lane_1_o    = lane_q[1];
   assign data_lane_2_o    = lane_q[2];
   assign data_lane_3_o    = lane_q[3];
   assign data_lane_1_oe_o = drive;
   assign data_lane_0_oe_o = drive & multi;
   assign data_lane_2_oe_o = drive & quad_on;
   assign data_lane_3_oe_o = drive & quad_on;

   // write protect freeze of block protect bits
   always @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         bp_frozen_o <= 1'b0;
         bp_held_o   <= 4'h0;
      end
      else
      begin
         // write protect off under quad enable; freeze when low
         bp_frozen_o <= ~wp_n_s & ~quad_enable_bit_i;
         if (wp_n_s || quad_enable_bit_i)
            bp_held_o <= block_protect_bits_i;
      end
   end

   // page program byte counter
   // one to 256 bytes per page program
   assign prog_len_ok_o = (prog_count_o != {`SFPI_CNT_W{1'b0}}) & ~prog_over_o;

   always @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         prog_count_o <= {`SFPI_CNT_W{1'b0}};
         prog_over_o  <= 1'b0;
      end
      else if (!prog_phase_i || cs_fall)
      begin
         prog_count_o <= {`SFPI_CNT_W{1'b0}};
         prog_over_o  <= 1'b0;
      end
      else if (rx_valid_o)
      begin
         if (prog_count_o == `SFPI_PAGE_BYTES)
            prog_over_o <= 1'b1;
         else
            prog_count_o <= prog_count_o + 9'h001;
      end
   end

endmodule // sfpi_pin_if

`default_nettype wire

// File: design/sfpi_sync.v
// Purpose: two-stage synchroniser for asynchronous pin levels
// Assumes: each bit is an independent level
// Notes:   stage one feeds only stage two
`timescale 1ns/10ps
`default_nettype none

module sfpi_sync
#(
   parameter WIDTH = 5,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
)
(
   // clock and reset
   input  wire             ref_clk_i,
   input  wire             rst_n_i,
   // levels
   input  wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);

   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1)
      begin : g_bit
         reg meta_q;
         reg stable_q;
         always @(posedge ref_clk_i)
         begin
            if (!rst_n_i)
            begin
               meta_q   <= INIT[g];
               stable_q <= INIT[g];
            end
            else
            begin
               meta_q   <= async_i[g];
               stable_q <= meta_q;
            end
         end
         assign sync_o[g] = stable_q;
      end
   endgenerate

endmodule // sfpi_sync

`default_nettype wire

// File: shared/sfpi_map.vh
// Purpose: constants for the serial flash pin interface
// Assumes: 16 Mbit array, byte addressed, 24-bit address field
// Notes:   definitions only
`ifndef SFPI_MAP_VH
`define SFPI_MAP_VH

// read data lane modes
`define SFPI_MODE_SINGLE   2'h0
`define SFPI_MODE_DUAL     2'h1
`define SFPI_MODE_QUAD     2'h2

// bits shifted per falling edge in each mode
`define SFPI_STEP_SINGLE   4'h1
`define SFPI_STEP_DUAL     4'h2
`define SFPI_STEP_QUAD     4'h4
`define SFPI_BYTE_BITS     4'h8

// erase granularity codes
`define SFPI_ERASE_PAGE    2'h0
`define SFPI_ERASE_SUB     2'h1
`define SFPI_ERASE_SECTOR  2'h2
`define SFPI_ERASE_ARRAY   2'h3

// array geometry
`define SFPI_ADDR_W        24
`define SFPI_ARRAY_W       21
`define SFPI_SECTOR_LSB    16
`define SFPI_SECTOR_W      5
`define SFPI_PAGE_LSB      8
`define SFPI_PAGE_W        13
`define SFPI_SUB_LSB_DEF   12

// page program byte count
`define SFPI_PAGE_BYTES    9'h100
`define SFPI_CNT_W         9

`endif

// File: tb/sfpi_host_model.sv
// Purpose: serial host driving the flash pins in clock mode 3
// Assumes: sck period of eight ref clocks
// Notes:   tasks are called from the bench
`timescale 1ns/10ps
`default_nettype none
module sfpi_host_model
(
   // clock
   input  wire logic       clk_i,
   // pins
   input  wire logic [3:0] lane_i,
   output var  logic       cs_n_o,
   output var  logic       sck_o,
   output var  logic       si_o,
   output var  logic       hold_n_o
);
   initial
   begin
      cs_n_o = 1'b1;
      sck_o = 1'b1;
      si_o = 1'b1;
      hold_n_o = 1'b1;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic sel(input logic v);
      @(posedge clk_i) cs_n_o <= v;
      cyc(8);
   endtask
   task automatic hold(input logic v);
      @(posedge clk_i) hold_n_o <= v;
      cyc(8);
   endtask
   // set on fall, sample on rise
   task automatic bit_x(input logic b, output logic [3:0] q);
      @(posedge clk_i);
      sck_o <= 1'b0;
      si_o <= b;
      cyc(4);
      sck_o <= 1'b1;
      q = lane_i;
      cyc(3);
   endtask
   task automatic send(input logic [7:0] b, input int n);
      logic [3:0] q;
      for (int i = 7; i > 7 - n; i--)
         bit_x(b[i], q);
      cyc(6);
   endtask
endmodule // sfpi_host_model
`default_nettype wire

// File: tb/sfpi_pin_assertions.sv
// Purpose: port checks for the serial flash pin layer
// Assumes: one clock domain, reset synchronous active low
// Notes:   bound into every sfpi_pin_if
`timescale 1ns/10ps
`default_nettype none
module sfpi_pin_chk
(
   // clock and reset
   input wire logic        ref_clk_i,
   input wire logic        rst_n_i,
   // inputs watched
   input wire logic        cs_n_i,
   input wire logic        busy_i,
   input wire logic        quad_enable_bit_i,
   input wire logic [1:0]  tx_mode_i,
   input wire logic [23:0] addr_i,
   // outputs watched
   input wire logic        data_lane_0_oe_o,
   input wire logic        data_lane_1_oe_o,
   input wire logic        data_lane_2_oe_o,
   input wire logic        data_lane_3_oe_o,
   input wire logic        rx_valid_o,
   input wire logic        tx_take_o,
   input wire logic [8:0]  prog_count_o,
   input wire logic        prog_over_o,
   input wire logic [4:0]  sector_o,
   input wire logic [12:0] page_o,
   input wire logic        selected_o,
   input wire logic        active_o,
   input wire logic        standby_o,
   input wire logic        armed_o,
   input wire logic        paused_o,
   input wire logic        bp_frozen_o,
   input wire logic [3:0]  bp_held_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_cs_float: assert property (cs_n_i [*6] |-> !data_lane_1_oe_o)
      else $error("lane 1 driven while deselected");
   a_sel_active: assert property ((!cs_n_i) [*6] |-> active_o && !standby_o)
      else $error("selected device not active");
   a_busy_active: assert property (busy_i [*5] |-> active_o && !standby_o)
      else $error("standby during internal cycle");
   a_armed_gate: assert property (!armed_o |-> !rx_valid_o && !tx_take_o)
      else $error("transfer before first select edge");
   a_pause_float: assert property (paused_o |->
      !(data_lane_0_oe_o | data_lane_1_oe_o | data_lane_2_oe_o | data_lane_3_oe_o))
      else $error("lane driven while paused");
   a_pause_sel: assert property ($rose(paused_o) |-> selected_o && !quad_enable_bit_i)
      else $error("pause taken when not allowed");
   a_dual_pair: assert property (data_lane_0_oe_o |-> data_lane_1_oe_o && tx_mode_i != 2'h0)
      else $error("lane 0 driven outside wide read");
   a_lane2_qe: assert property (data_lane_2_oe_o |-> quad_enable_bit_i && data_lane_1_oe_o)
      else $error("lane 2 driven without quad enable");
   a_lane3_qe: assert property (data_lane_3_oe_o |-> quad_enable_bit_i && data_lane_2_oe_o)
      else $error("lane 3 driven without quad enable");
   a_bp_freeze: assert property (bp_frozen_o && $past(bp_frozen_o) |-> $stable(bp_held_o))
      else $error("protect bits changed while frozen");
   a_prog_limit: assert property ($rose(prog_over_o) |-> prog_count_o == 9'h100)
      else $error("overflow flagged below 256 bytes");
   a_addr_split: assert property (sector_o == addr_i[20:16] && page_o == addr_i[20:8])
      else $error("address split wrong");
endmodule // sfpi_pin_chk

bind sfpi_pin_if sfpi_pin_chk u_chk
(
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .busy_i(busy_i),
   .quad_enable_bit_i(quad_enable_bit_i), .tx_mode_i(tx_mode_i), .addr_i(addr_i),
   .data_lane_0_oe_o(data_lane_0_oe_o), .data_lane_1_oe_o(data_lane_1_oe_o),
   .data_lane_2_oe_o(data_lane_2_oe_o), .data_lane_3_oe_o(data_lane_3_oe_o),
   .rx_valid_o(rx_valid_o), .tx_take_o(tx_take_o), .prog_count_o(prog_count_o),
   .prog_over_o(prog_over_o), .sector_o(sector_o), .page_o(page_o),
   .selected_o(selected_o), .active_o(active_o), .standby_o(standby_o),
   .armed_o(armed_o), .paused_o(paused_o), .bp_frozen_o(bp_frozen_o), .bp_held_o(bp_held_o)
);
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: self-checking bench for the flash pin layer
// Assumes: host model in mode 3, sck 160 ns
// Notes:   lanes resolved from device enables
`timescale 1ns/10ps
`default_nettype none
`include "sfpi_map.vh"
module tb_top;
   logic ref_clk_i, rst_n_i, quad_enable_bit_i, busy_i, tx_en_i, prog_phase_i, wp_n, got_f;
   logic [3:0] block_protect_bits_i;
   logic [1:0] tx_mode_i, erase_kind_i;
   logic [7:0] tx_byte_i, got_b;
   logic [23:0] addr_i;
   int errors, comparisons, nvalid, ntake, nframe;
   wire cs_n_i, sck_i, si, hold_n, data_lane_0_i, wp_n_i, hold_n_i, data_lane_1;
   wire data_lane_0_o, data_lane_0_oe_o, data_lane_1_o, data_lane_1_oe_o, data_lane_2_o;
   wire data_lane_2_oe_o, data_lane_3_o, data_lane_3_oe_o, rx_valid_o, rx_first_o, tx_take_o;
   wire prog_len_ok_o, prog_over_o, selected_o, active_o, standby_o, armed_o, paused_o;
   wire bp_frozen_o, frame_end_o;
   wire [7:0] rx_byte_o;
   wire [8:0] prog_count_o;
   wire [4:0] sector_o;
   wire [12:0] page_o;
   wire [20:0] erase_first_o, erase_last_o;
   wire [3:0] bp_held_o;
   // device wins a lane while enabled
   assign data_lane_0_i = data_lane_0_oe_o ? data_lane_0_o : si;
   assign data_lane_1 = data_lane_1_oe_o ? data_lane_1_o : 1'bz;
   assign wp_n_i = data_lane_2_oe_o ? data_lane_2_o : wp_n;
   assign hold_n_i = data_lane_3_oe_o ? data_lane_3_o : hold_n;

   sfpi_pin_if uut
   (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .sck_i(sck_i),
      .data_lane_0_i(data_lane_0_i), .data_lane_0_o(data_lane_0_o),
      .data_lane_0_oe_o(data_lane_0_oe_o), .data_lane_1_o(data_lane_1_o),
      .data_lane_1_oe_o(data_lane_1_oe_o), .wp_n_i(wp_n_i), .data_lane_2_o(data_lane_2_o),
      .data_lane_2_oe_o(data_lane_2_oe_o), .hold_n_i(hold_n_i), .data_lane_3_o(data_lane_3_o),
      .data_lane_3_oe_o(data_lane_3_oe_o), .quad_enable_bit_i(quad_enable_bit_i),
      .block_protect_bits_i(block_protect_bits_i), .busy_i(busy_i), .rx_byte_o(rx_byte_o),
      .rx_valid_o(rx_valid_o), .rx_first_o(rx_first_o), .tx_en_i(tx_en_i),
      .tx_mode_i(tx_mode_i), .tx_byte_i(tx_byte_i), .tx_take_o(tx_take_o),
      .prog_phase_i(prog_phase_i), .prog_count_o(prog_count_o), .prog_len_ok_o(prog_len_ok_o),
      .prog_over_o(prog_over_o), .addr_i(addr_i), .erase_kind_i(erase_kind_i),
      .sector_o(sector_o), .page_o(page_o), .erase_first_o(erase_first_o),
      .erase_last_o(erase_last_o), .selected_o(selected_o), .active_o(active_o),
      .standby_o(standby_o), .armed_o(armed_o), .paused_o(paused_o),
      .bp_frozen_o(bp_frozen_o), .bp_held_o(bp_held_o), .frame_end_o(frame_end_o)
   );
   sfpi_host_model host (.clk_i(ref_clk_i), .lane_i({hold_n_i, wp_n_i, data_lane_1, data_lane_0_i}),
      .cs_n_o(cs_n_i), .sck_o(sck_i), .si_o(si), .hold_n_o(hold_n));

   initial
   begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i)
   begin
      if (rx_valid_o)
      begin
         got_b <= rx_byte_o;
         got_f <= rx_first_o;
         nvalid <= nvalid + 1;
      end
      if (tx_take_o)
         ntake <= ntake + 1;
      if (frame_end_o)
         nframe <= nframe + 1;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %0t %s: got %0h exp %0h", $time, what, got, exp);
      end
   endtask
   task automatic final_report;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic t_arm;
      chk(standby_o, 1, "standby after reset");
      host.send(8'hA5, 8);
      chk(nvalid, 0, "byte while unselected");
      chk(armed_o, 0, "armed early");
      host.sel(1'b0);
      chk(armed_o, 1, "armed");
      chk(selected_o, 1, "selected");
      chk(active_o, 1, "active");
      $display("done arm");
   endtask
   task automatic t_rx;
      host.send(8'hA5, 8);
      chk(got_b, 8'hA5, "rx byte");
      chk(got_f, 1, "first flag");
      host.send(8'h3C, 8);
      chk(got_b, 8'h3C, "rx second");
      chk(got_f, 0, "first flag again");
      $display("done rx");
   endtask
   task automatic t_hold;
      int n;
      n = nvalid;
      host.send(8'h96, 4);
      host.hold(1'b0);
      chk(paused_o, 1, "paused");
      chk(selected_o, 1, "kept selected");
      host.send(8'h00, 3);
      host.hold(1'b1);
      host.send(8'h60, 4);
      chk(got_b, 8'h96, "resumed byte");
      chk(nvalid, n + 1, "byte count");
      quad_enable_bit_i <= 1'b1;
      host.hold(1'b0);
      chk(paused_o, 0, "pause with quad");
      host.hold(1'b1);
      quad_enable_bit_i <= 1'b0;
      host.sel(1'b1);
      host.hold(1'b0);
      chk(paused_o, 0, "pause unselected");
      host.hold(1'b1);
      host.sel(1'b0);
      $display("done hold");
   endtask
   task automatic t_tx(input logic [1:0] m, input logic qe, input logic [7:0] b, input int w);
      logic [3:0] q;
      logic [7:0] acc;
      int n;
      n = ntake;
      quad_enable_bit_i <= qe;
      tx_mode_i <= m;
      tx_byte_i <= b;
      tx_en_i <= 1'b1;
      host.cyc(2);
      for (int i = 0; i < 8 / w; i++)
      begin
         host.bit_x(1'b1, q);
         acc = (w == 4) ? {acc[3:0], q} : (w == 2) ? {acc[5:0], q[1:0]} : {acc[6:0], q[1]};
         chk(data_lane_0_oe_o, w > 1, "lane 0 enable");
         chk(data_lane_2_oe_o, w == 4, "lane 2 enable");
      end
      chk(acc, b, "read data");
      chk(ntake, n + 1, "one byte taken");
      tx_en_i <= 1'b0;
      quad_enable_bit_i <= 1'b0;
      host.cyc(4);
      chk(data_lane_1_oe_o, 0, "lane released");
      $display("done tx %0d", w);
   endtask
   task automatic t_desel;
      int n;
      n = nframe;
      tx_mode_i <= `SFPI_MODE_SINGLE;
      tx_en_i <= 1'b1;
      busy_i <= 1'b1;
      host.send(8'h00, 2);
      chk(data_lane_1_oe_o, 1, "driving");
      host.sel(1'b1);
      chk(data_lane_1_oe_o, 0, "float deselected");
      chk(nframe, n + 1, "frame end");
      chk(standby_o, 0, "busy standby");
      busy_i <= 1'b0;
      tx_en_i <= 1'b0;
      host.cyc(6);
      chk(standby_o, 1, "standby");
      chk(active_o, 0, "inactive");
      host.sel(1'b0);
      $display("done deselect");
   endtask
   task automatic t_prog;
      prog_phase_i <= 1'b1;
      host.cyc(2);
      chk(prog_len_ok_o, 0, "empty page");
      for (int i = 0; i < 256; i++)
         host.send(i[7:0], 8);
      chk(prog_count_o, 9'h100, "count");
      chk(prog_len_ok_o, 1, "full page ok");
      chk(prog_over_o, 0, "no overflow");
      host.send(8'h00, 8);
      chk(prog_over_o, 1, "overflow");
      chk(prog_len_ok_o, 0, "overflow not ok");
      prog_phase_i <= 1'b0;
      $display("done program");
   endtask
   task automatic t_wp;
      block_protect_bits_i <= 4'h5;
      host.cyc(4);
      chk(bp_held_o, 4'h5, "tracked");
      wp_n <= 1'b0;
      host.cyc(6);
      block_protect_bits_i <= 4'hA;
      host.cyc(6);
      chk(bp_held_o, 4'h5, "frozen");
      chk(bp_frozen_o, 1, "frozen flag");
      quad_enable_bit_i <= 1'b1;
      host.cyc(6);
      chk(bp_held_o, 4'hA, "quad unfreezes");
      chk(bp_frozen_o, 0, "quad flag off");
      quad_enable_bit_i <= 1'b0;
      wp_n <= 1'b1;
      $display("done protect");
   endtask
   task automatic t_addr;
      int lsb[4] = '{8, 12, 16, 21};
      logic [20:0] f;
      addr_i <= 24'h1A_BCDE;
      for (int k = 0; k < 4; k++)
      begin
         erase_kind_i <= k[1:0];
         host.cyc(2);
         f = 21'h1A_BCDE >> lsb[k] << lsb[k];
         chk(erase_first_o, f, "erase first");
         chk(erase_last_o, f | ((21'h1 << lsb[k]) - 1), "erase last");
      end
      chk(sector_o, 5'h1A, "sector");
      chk(page_o, 13'h1ABC, "page");
      $display("done address");
   endtask

   initial
   begin
      errors = 0;
      comparisons = 0;
      nvalid = 0;
      ntake = 0;
      nframe = 0;
      rst_n_i = 1'b0;
      {quad_enable_bit_i, busy_i, tx_en_i, prog_phase_i} = 4'h0;
      wp_n = 1'b1;
      block_protect_bits_i = 4'h0;
      {tx_mode_i, erase_kind_i, tx_byte_i} = 12'h000;
      addr_i = 24'h00_0000;
      host.cyc(4);
      rst_n_i <= 1'b1;
      host.cyc(3);
      t_arm;
      t_rx;
      t_hold;
      t_tx(`SFPI_MODE_SINGLE, 1'b0, 8'hC3, 1);
      t_tx(`SFPI_MODE_DUAL, 1'b0, 8'h5A, 2);
      t_tx(`SFPI_MODE_QUAD, 1'b1, 8'hB4, 4);
      t_tx(`SFPI_MODE_QUAD, 1'b0, 8'h69, 1);
      t_desel;
      t_prog;
      t_wp;
      t_addr;
      final_report;
   end
   initial
   begin
      repeat (60000) @(posedge ref_clk_i);
      errors++;
      final_report;
   end
endmodule // tb_top
`default_nettype wire
